// ---- mme_pkg.sv ----
package mme_pkg;

    // ------------------------------------------------------------
    // opcode layout
    // ------------------------------------------------------------
    // move acc to file: 0110 111a ffff ffff
    localparam logic [6:0] OPC_MOVE_ACC_TO_FILE = 7'h37;
    // multiply literal by acc: 0000 1101 kkkk kkkk
    localparam logic [7:0] OPC_MULTIPLY_LITERAL = 8'h0d;
    // multiply acc by file: 0000 001a ffff ffff
    localparam logic [6:0] OPC_MULTIPLY_FILE    = 7'h01;
    localparam int         BANK_BIT_POS         = 8;

    // ------------------------------------------------------------
    // addressing
    // ------------------------------------------------------------
    localparam logic [7:0] INDEXED_LIMIT        = 8'h5f;
    // access bank low half sits in bank 0, upper half in bank 15
    localparam logic [7:0] ACCESS_SPLIT         = 8'h60;
    localparam logic [3:0] ACCESS_HIGH_BANK     = 4'hf;
    localparam logic [3:0] ACCESS_LOW_BANK      = 4'h0;

    // ------------------------------------------------------------
    // reset values and phases
    // ------------------------------------------------------------
    localparam logic [7:0] PRODUCT_RESET        = 8'h00;
    localparam int         PHASE_COUNT          = 4;

    typedef enum logic [1:0] {
        MME_PH_DECODE,
        MME_PH_READ,
        MME_PH_PROCESS,
        MME_PH_WRITE
    } mme_phase_t;

    typedef enum logic [1:0] {
        MME_OP_NONE,
        MME_OP_MOVE,
        MME_OP_MUL_LIT,
        MME_OP_MUL_FILE
    } mme_op_t;

endpackage

// ---- mme_addr_gen.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------
// file operand address generation
// ----------------------------------------------------------------
module mme_addr_gen (
    // operand fields
    input  wire logic [7:0]  file_addr_i,
    input  wire logic        bank_bit_i,
    // core state
    input  wire logic [3:0]  bank_select_register_i,
    input  wire logic        ext_set_en_i,
    input  wire logic [11:0] index_base_i,
    // resolved address
    output logic      [11:0] data_addr_o,
    output logic             indexed_o
);

    // pick access bank, selected bank or indexed offset
    always_comb begin
        indexed_o = ext_set_en_i && !bank_bit_i
                    && (file_addr_i <= mme_pkg::INDEXED_LIMIT);
        if (indexed_o) begin
            data_addr_o = index_base_i + {4'h0, file_addr_i};
        end else if (bank_bit_i) begin
            data_addr_o = {bank_select_register_i, file_addr_i};
        end else if (file_addr_i < mme_pkg::ACCESS_SPLIT) begin
            data_addr_o = {mme_pkg::ACCESS_LOW_BANK, file_addr_i};
        end else begin
            // upper access half maps onto special function registers
            data_addr_o = {mme_pkg::ACCESS_HIGH_BANK, file_addr_i};
        end
    end

endmodule

// ---- mme_core.sv ----
`timescale 1ns/100ps
module mme_core (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    // instruction stream, one word per instruction cycle
    input  wire logic        instr_valid_i,
    input  wire logic [15:0] instr_word_i,
    // core state
    input  wire logic [7:0]  acc_i,
    input  wire logic [3:0]  bank_select_register_i,
    input  wire logic        ext_set_en_i,
    input  wire logic [11:0] index_base_i,
    input  wire logic [4:0]  status_i,
    // data memory port
    output logic      [11:0] mem_addr_o,
    output logic             mem_rd_o,
    input  wire logic [7:0]  mem_rdata_i,
    output logic             mem_wr_o,
    output logic      [7:0]  mem_wdata_o,
    // results
    output logic      [7:0]  product_high_byte_o,
    output logic      [7:0]  product_low_byte_o,
    output logic      [4:0]  status_o,
    output logic             instr_ready_o,
    output logic             instr_done_o,
    output logic             indexed_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        mme_pkg::mme_phase_t phase;
        mme_pkg::mme_op_t    op;
        logic [15:0]         word;
        logic [7:0]          operand;
        logic [7:0]          acc_snap;
        logic [15:0]         product;
        logic [7:0]          prod_hi;
        logic [7:0]          prod_lo;
        logic [11:0]         addr;
        logic                rd;
        logic                wr;
        logic [7:0]          wdata;
        logic                done;
        logic                indexed;
    } mme_state_t;

    mme_state_t  s_q;
    mme_state_t  s_d;
    logic [11:0] gen_addr;
    logic        gen_indexed;
    mme_pkg::mme_op_t dec_op;

    // ------------------------------------------------------------
    // address generation
    // ------------------------------------------------------------
    mme_addr_gen u_addr (
        .file_addr_i            (s_q.word[7:0]),
        .bank_bit_i             (s_q.word[mme_pkg::BANK_BIT_POS]),
        .bank_select_register_i (bank_select_register_i),
        .ext_set_en_i           (ext_set_en_i),
        .index_base_i           (index_base_i),
        .data_addr_o            (gen_addr),
        .indexed_o              (gen_indexed)
    );

    // ------------------------------------------------------------
    // opcode decode
    // ------------------------------------------------------------
    // other opcodes fall through as no operation in this datapath
    always_comb begin
        if (instr_word_i[15:9] == mme_pkg::OPC_MOVE_ACC_TO_FILE) begin
            dec_op = mme_pkg::MME_OP_MOVE;
        end else if (instr_word_i[15:8] == mme_pkg::OPC_MULTIPLY_LITERAL) begin
            dec_op = mme_pkg::MME_OP_MUL_LIT;
        end else if (instr_word_i[15:9] == mme_pkg::OPC_MULTIPLY_FILE) begin
            dec_op = mme_pkg::MME_OP_MUL_FILE;
        end else begin
            dec_op = mme_pkg::MME_OP_NONE;
        end
    end

    // ------------------------------------------------------------
    // four phase sequencer
    // ------------------------------------------------------------
    // one phase per clock, so an instruction cycle is four clocks
    always_comb begin
        s_d      = s_q;
        s_d.rd   = 1'b0;
        s_d.wr   = 1'b0;
        s_d.done = 1'b0;
        unique case (s_q.phase)
            mme_pkg::MME_PH_DECODE: begin
                if (instr_valid_i) begin
                    s_d.word  = instr_word_i;
                    s_d.op    = dec_op;
                    s_d.phase = mme_pkg::MME_PH_READ;
                end
            end
            mme_pkg::MME_PH_READ: begin
                // address is 8-bit offset inside chosen bank, or index base plus offset when indexed
                s_d.addr     = gen_addr;
                s_d.indexed  = gen_indexed;
                s_d.acc_snap = acc_i;
                if (s_q.op == mme_pkg::MME_OP_MUL_LIT) begin
                    s_d.operand = s_q.word[7:0];
                end
                // read is a pure fetch, the source stays intact
                s_d.rd    = (s_q.op == mme_pkg::MME_OP_MUL_FILE);
                s_d.phase = mme_pkg::MME_PH_PROCESS;
            end
            mme_pkg::MME_PH_PROCESS: begin
                if (s_q.op == mme_pkg::MME_OP_MUL_FILE) begin
                    s_d.operand = mem_rdata_i;
                    s_d.product = s_q.acc_snap * mem_rdata_i;
                end else begin
                    s_d.product = s_q.acc_snap * s_q.operand;
                end
                s_d.phase = mme_pkg::MME_PH_WRITE;
            end
            mme_pkg::MME_PH_WRITE: begin
                if (s_q.op == mme_pkg::MME_OP_MOVE) begin
                    s_d.wr    = 1'b1;
                    s_d.wdata = s_q.acc_snap;
                end else if (s_q.op == mme_pkg::MME_OP_MUL_LIT
                             || s_q.op == mme_pkg::MME_OP_MUL_FILE) begin
                    s_d.prod_hi = s_q.product[15:8];
                    s_d.prod_lo = s_q.product[7:0];
                end
                s_d.done  = (s_q.op != mme_pkg::MME_OP_NONE);
                s_d.phase = mme_pkg::MME_PH_DECODE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s_q         <= '0;
            s_q.phase   <= mme_pkg::MME_PH_DECODE;
            s_q.op      <= mme_pkg::MME_OP_NONE;
            s_q.prod_hi <= mme_pkg::PRODUCT_RESET;
            s_q.prod_lo <= mme_pkg::PRODUCT_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // memory strobes are registered one-cycle pulses
    assign mem_addr_o          = s_q.addr;
    assign mem_rd_o            = s_q.rd;
    assign mem_wr_o            = s_q.wr;
    assign mem_wdata_o         = s_q.wdata;
    assign product_high_byte_o = s_q.prod_hi;
    assign product_low_byte_o  = s_q.prod_lo;
    assign instr_done_o        = s_q.done;
    assign indexed_o           = s_q.indexed;
    assign instr_ready_o       = (s_q.phase == mme_pkg::MME_PH_DECODE);
    // no overflow, carry or zero detection: flags pass straight through
    assign status_o            = status_i;

endmodule

// ---- mme_core_asserts.sv ----
`timescale 1ns/100ps
module mme_core_asserts (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        instr_valid_i,
    input  wire logic [15:0] instr_word_i,
    input  wire logic        ext_set_en_i,
    input  wire logic [4:0]  status_i,
    input  wire logic        mem_rd_o,
    input  wire logic        mem_wr_o,
    input  wire logic [7:0]  product_high_byte_o,
    input  wire logic [7:0]  product_low_byte_o,
    input  wire logic [4:0]  status_o,
    input  wire logic        instr_ready_o,
    input  wire logic        instr_done_o,
    input  wire logic        indexed_o
);
    // ------------------------------------------------------------
    // port checks
    // ------------------------------------------------------------
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    logic take;
    logic mov;
    logic lit;
    // decode once, the opcode fields are fixed
    assign take = instr_valid_i && instr_ready_o;
    assign mov  = instr_word_i[15:9] == mme_pkg::OPC_MOVE_ACC_TO_FILE;
    assign lit  = instr_word_i[15:8] == mme_pkg::OPC_MULTIPLY_LITERAL;
    a_status_kept: assert property (status_o == status_i)
        else $error("status changed");
    a_cycle_len: assert property (take |=> !instr_ready_o [*3] ##1 instr_ready_o)
        else $error("instruction cycle length wrong");
    a_move_writes: assert property (take && mov |-> ##4 instr_done_o && mem_wr_o)
        else $error("move did not write");
    a_other_no_wr: assert property (take && !mov |-> ##4 !mem_wr_o)
        else $error("write outside move");
    a_lit_no_rd: assert property (take && lit |-> ##2 !mem_rd_o)
        else $error("literal multiply read memory");
    a_rd_to_done: assert property (mem_rd_o |-> ##2 instr_done_o)
        else $error("read not followed by done");
    a_wr_pulse: assert property (mem_wr_o |=> !mem_wr_o)
        else $error("write longer than a cycle");
    a_prod_hold: assert property (!instr_done_o && !$past(rst_i) |->
        $stable({product_high_byte_o, product_low_byte_o})) else $error("product moved");
    a_idx_used: assert property (take && mov && ext_set_en_i && !instr_word_i[8] &&
        instr_word_i[7:0] <= 8'h5f |-> ##4 indexed_o) else $error("indexed mode missed");
    a_bank_no_idx: assert property (take && mov && instr_word_i[8] |-> ##4 !indexed_o)
        else $error("indexed with bank bit set");
endmodule

// ---- move_multiply_execute_tb_top.sv ----
`timescale 1ns/100ps
module move_multiply_execute_tb_top;
    typedef struct packed {
        logic [15:0] w;
        logic [7:0]  acc, rd;
        logic [3:0]  bank_select_register;
        logic        ext;
        logic [1:0]  kind;
        logic [15:0] exp_prod;
    } mme_row_t;
    logic        sys_clk_i = 0, rst_i = 1, instr_valid_i = 0, ext_set_en_i = 0;
    logic [15:0] instr_word_i = 16'h0000;
    logic [11:0] index_base_i = 12'h100;
    mme_row_t    extra_row;
    logic [7:0]  acc_i = 8'h00, mem_rdata_i = 8'h00, hi, lo, mem_wdata_o;
    logic [3:0]  bank_select_register_i = 4'h0;
    logic [4:0]  status_i = 5'h00, status_o;
    logic [11:0] mem_addr_o;
    logic        mem_rd_o, mem_wr_o, instr_ready_o, instr_done_o, indexed_o;
    int          miscompares = 0, cmp_count = 0, nrd, nwr;
    // kinds: 0 move, 1 literal multiply, 2 file multiply, 3 unknown
    // last field: product expected after the row, moves and unknowns keep the old one
    mme_row_t rows [9] = '{'{16'h6fff, 8'h4f, 8'h00, 4'h5, 1'b0, 2'd0, 16'h0000},
        '{16'h6e5f, 8'h11, 8'h00, 4'h5, 1'b0, 2'd0, 16'h0000},
        '{16'h6e60, 8'h22, 8'h00, 4'h5, 1'b1, 2'd0, 16'h0000},
        '{16'h6e5f, 8'h33, 8'h00, 4'h5, 1'b1, 2'd0, 16'h0000},
        '{16'h0dc4, 8'he2, 8'h00, 4'h0, 1'b0, 2'd1, 16'had08},
        '{16'h0d00, 8'hff, 8'h00, 4'h0, 1'b0, 2'd1, 16'h0000},
        '{16'h0310, 8'hc4, 8'hb5, 4'h3, 1'b0, 2'd2, 16'h8a94},
        '{16'h0220, 8'hff, 8'hff, 4'h3, 1'b1, 2'd2, 16'hfe01},
        '{16'hffff, 8'h12, 8'h34, 4'h3, 1'b0, 2'd3, 16'hfe01}};
    always #4 sys_clk_i = ~sys_clk_i;
    mme_core mme_core_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
        .instr_word_i(instr_word_i), .acc_i(acc_i), .ext_set_en_i(ext_set_en_i),
        .bank_select_register_i(bank_select_register_i), .index_base_i(index_base_i),
        .status_i(status_i), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
        .mem_rdata_i(mem_rdata_i), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o),
        .product_high_byte_o(hi), .product_low_byte_o(lo), .status_o(status_o),
        .instr_ready_o(instr_ready_o), .instr_done_o(instr_done_o), .indexed_o(indexed_o));
    // ------------------------------------------------------------
    // compare and close
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // one instruction from a negedge in decode to the negedge of the next decode
    task automatic run(input mme_row_t r, input int i);
        logic        ei;
        logic [11:0] ea;
        ei = !r.w[8] && r.ext && r.w[7:0] <= 8'h5f;
        ea = ei ? index_base_i + {4'h0, r.w[7:0]} : r.w[8] ? {r.bank_select_register, r.w[7:0]} :
             (r.w[7:0] < 8'h60) ? {4'h0, r.w[7:0]} : {4'hf, r.w[7:0]};
        chk("ready", instr_ready_o, 1);
        {instr_valid_i, instr_word_i, acc_i, mem_rdata_i} = {1'b1, r.w, r.acc, r.rd};
        {bank_select_register_i, ext_set_en_i, status_i} = {r.bank_select_register, r.ext, i[4:0] ^ 5'h15};
        nrd = 0;
        nwr = 0;
        repeat (3) begin
            @(negedge sys_clk_i);
            instr_valid_i = 0;
            nrd += (mem_rd_o === 1'b1);
            nwr += (mem_wr_o === 1'b1);
        end
        // results land with the return to decode, one more falling edge on
        @(negedge sys_clk_i);
        chk("done", instr_done_o, r.kind != 3);
        chk("reads", nrd, r.kind == 2);
        chk("early writes", nwr, 0);
        chk("write", mem_wr_o, r.kind == 0);
        chk("product", {hi, lo}, r.exp_prod);
        chk("status", status_o, status_i);
        if (r.kind == 0) chk("wdata", mem_wdata_o, r.acc);
        if (r.kind == 0 || r.kind == 2) chk("addr", mem_addr_o, ea);
        if (r.kind == 0 || r.kind == 2) chk("indexed", indexed_o, ei);
    endtask
    // ------------------------------------------------------------
    // sequence: reset, table back to back, reset in mid-instruction
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        rst_i = 0;
        chk("reset product", {hi, lo}, 16'h0000);
        foreach (rows[i]) run(rows[i], i);
        // indexed move from another base, product left from the last multiply
        extra_row = rows[3];
        extra_row.exp_prod = 16'hfe01;
        index_base_i = 12'h3a0;
        run(extra_row, 9);
        {instr_valid_i, instr_word_i, acc_i} = {1'b1, 16'h0dff, 8'hff};
        @(negedge sys_clk_i);
        {instr_valid_i, rst_i} = 2'b01;
        @(negedge sys_clk_i);
        rst_i = 0;
        repeat (4) @(negedge sys_clk_i) chk("aborted done", instr_done_o, 0);
        chk("aborted product", {hi, lo}, 16'h0000);
        chk("ready after reset", instr_ready_o, 1);
        end_of_test();
    end
    // hang guard, the run needs well under a microsecond
    initial begin
        #20000;
        miscompares++;
        end_of_test();
    end
endmodule
bind mme_core mme_core_asserts mme_core_asserts_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .instr_valid_i(instr_valid_i), .instr_word_i(instr_word_i), .ext_set_en_i(ext_set_en_i),
    .status_i(status_i), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .status_o(status_o),
    .product_high_byte_o(product_high_byte_o), .product_low_byte_o(product_low_byte_o),
    .instr_ready_o(instr_ready_o), .instr_done_o(instr_done_o), .indexed_o(indexed_o));
